/* File: src/tpg_cfg.svh */
/*
 * Constants for the programmable pulse generator: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and an APB bus with byte addresses.
 */
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

`define TPG_CLK_HZ        50000000
`define TPG_MS_NS         1000000
`define TPG_CLK_NS        20
`define TPG_MS_CYC        (`TPG_MS_NS / `TPG_CLK_NS)

`define TPG_OFS_CTRL      12'h000
`define TPG_OFS_WIDTH     12'h004
`define TPG_OFS_PERIOD    12'h008
`define TPG_OFS_HOUR_OFS  12'h00C
`define TPG_OFS_MATCH     12'h010
`define TPG_OFS_DAY       12'h014
`define TPG_OFS_STATUS    12'h018

`define TPG_CTRL_POL      3
`define TPG_CTRL_DCF_MOD  4
`define TPG_CTRL_SVC      5
`define TPG_CTRL_ARM      8

`define TPG_WIDTH_RST     16'h000A
`define TPG_PERIOD_MAX    16'hEA60
`define TPG_HOUR_OFS_MAX  12'hE0F

`define TPG_SLOW_MIN_MS   16'h07D0
`define TPG_SLOW_HOUR_MS  16'h0FA0
`define TPG_SLOW_DAY_MS   16'h1770
`define TPG_DCF_ZERO_MS   16'h0064
`define TPG_DCF_ONE_MS    16'h00C8
`define TPG_DCF_MOD59_MS  16'h01F4
`define TPG_IRIG_ZERO_MS  16'h0002
`define TPG_IRIG_ONE_MS   16'h0005
`define TPG_IRIG_REF_MS   16'h0008

`endif

/* File: src/tpg_pkg.sv */
/*
 * Types of the programmable pulse generator.
 * Numeric constants live in tpg_cfg.svh.
 */
package tpg_pkg;

  typedef enum logic [2:0] {
    TPG_MODE_OFF,
    TPG_MODE_SPP,
    TPG_MODE_PPH,
    TPG_MODE_PPD,
    TPG_MODE_SGL,
    TPG_MODE_SLOW,
    TPG_MODE_IRIG,
    TPG_MODE_DCF
  } tpg_mode_t;

endpackage

/* File: src/tpg_pulse_gen.sv */
/*
 * Programmable pulse output generator with APB register access.
 * Assumes a disciplined timebase: pps_i is a one-cycle pulse at each second
 * start, and the time inputs describe that second and stay stable through it.
 */
`timescale 1ns/1ns
`include "tpg_cfg.svh"

// Functional notes
// - Seconds-per-pulse mode pulses every N seconds, N from 1 to 60000; N = 0 gives no pulses.
// - Hourly mode pulses at a set offset 0..3599 seconds into each hour.
// - Daily mode pulses when hour, minute, second and millisecond match.
// - Single trigger pulses when day, hour, minute, second, millisecond all match.
// - Slow code holds 2 s per minute, 4 s per hour, 6 s per day.
// - Polarity setting picks positive or negative pulses for programmable modes.
// - One mode outputs its own unmodulated IRIG-B time code.
// - Time-code mode sends a minute frame with date, time and markers.
// - Time-code frame timing comes from the disciplined timebase only.
// - Second 59 is silent, or a 0.5 s pulse in the modified variant.
// - Second 0 is the minute marker, a 0.1 s pulse.
// - Zone bits are 0.1/0.2 s in standard time, swapped in summer.
// - Leap announcement bit is a 0.2 s pulse when leap is pending.
// - An announcement bit warns of a coming standard/summer switch.
// - Second 15 carries the service-request marker bit.
// - Programmable pulses rise on time with configured period and width.
// - Single trigger fires at most once per year at its set time.
module tpg_pulse_gen (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        pps_i,
  input  wire logic [5:0]  utc_sec_i,
  input  wire logic [5:0]  utc_min_i,
  input  wire logic [4:0]  utc_hour_i,
  input  wire logic [8:0]  day_of_year_i,
  input  wire logic [6:0]  year_i,
  input  wire logic [3:0]  month_i,
  input  wire logic [4:0]  mday_i,
  input  wire logic [2:0]  wday_i,
  input  wire logic        summer_time_i,
  input  wire logic        zone_change_pending_i,
  input  wire logic        leap_pending_i,
  output logic             pulse_o
);

  function automatic logic [7:0] bcd8(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'd10;
    return {t[3:0], 4'(v - 7'(t * 7'd10))};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  tpg_pkg::tpg_mode_t mode_cfg_r;
  tpg_pkg::tpg_mode_t mode_act_r;
  logic        pol_neg_r;
  logic        pol_act_r;
  logic        dcf_mod_r;
  logic        svc_req_r;
  logic        armed_r;
  logic [15:0] width_r;
  logic [15:0] period_r;
  logic [11:0] hour_ofs_r;
  logic [9:0]  m_ms_r;
  logic [5:0]  m_sec_r;
  logic [5:0]  m_min_r;
  logic [4:0]  m_hour_r;
  logic [8:0]  m_day_r;
  logic        out_r;

  logic        acc;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        fire_sgl;

  assign acc   = psel_i & penable_i;
  assign wr_en = acc & pready_o & pwrite_i;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `TPG_OFS_CTRL:     rd_mux = {26'h000_0000, svc_req_r, dcf_mod_r, pol_neg_r, mode_cfg_r};
      `TPG_OFS_WIDTH:    rd_mux = {16'h0000, width_r};
      `TPG_OFS_PERIOD:   rd_mux = {16'h0000, period_r};
      `TPG_OFS_HOUR_OFS: rd_mux = {20'h0_0000, hour_ofs_r};
      `TPG_OFS_MATCH:    rd_mux = {5'h00, m_hour_r, m_min_r, m_sec_r, m_ms_r};
      `TPG_OFS_DAY:      rd_mux = {23'h00_0000, m_day_r};
      `TPG_OFS_STATUS:   rd_mux = {27'h000_0000, out_r, armed_r, mode_act_r};
      default:           mapped = 1'b0;
    endcase
  end

  // One wait state keeps every bus output on a flip-flop
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      prdata_o  <= (acc & ~pready_o & ~pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_cfg_r <= tpg_pkg::TPG_MODE_OFF;
      pol_neg_r  <= 1'b0;
      dcf_mod_r  <= 1'b0;
      svc_req_r  <= 1'b0;
      width_r    <= `TPG_WIDTH_RST;
      period_r   <= 16'h0000;
      hour_ofs_r <= 12'h000;
      m_ms_r     <= 10'h000;
      m_sec_r    <= 6'h00;
      m_min_r    <= 6'h00;
      m_hour_r   <= 5'h00;
      m_day_r    <= 9'h000;
    end else if (wr_en) begin
      case (paddr_i)
        `TPG_OFS_CTRL: begin
          mode_cfg_r <= tpg_pkg::tpg_mode_t'(pwdata_i[2:0]);
          pol_neg_r  <= pwdata_i[`TPG_CTRL_POL];
          dcf_mod_r  <= pwdata_i[`TPG_CTRL_DCF_MOD];
          svc_req_r  <= pwdata_i[`TPG_CTRL_SVC];
        end
        `TPG_OFS_WIDTH:    width_r <= pwdata_i[15:0];
        `TPG_OFS_PERIOD:   period_r <= (pwdata_i[15:0] > `TPG_PERIOD_MAX) ? `TPG_PERIOD_MAX : pwdata_i[15:0];
        `TPG_OFS_HOUR_OFS: hour_ofs_r <= (pwdata_i[11:0] > `TPG_HOUR_OFS_MAX) ? `TPG_HOUR_OFS_MAX : pwdata_i[11:0];
        `TPG_OFS_MATCH: begin
          m_ms_r   <= pwdata_i[9:0];
          m_sec_r  <= pwdata_i[15:10];
          m_min_r  <= pwdata_i[21:16];
          m_hour_r <= pwdata_i[26:22];
        end
        `TPG_OFS_DAY:      m_day_r <= pwdata_i[8:0];
        default: ;
      endcase
    end
  end

  // arm once, disarm on firing; a new arm wins over the disarm
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      armed_r <= 1'b0;
    else
      armed_r <= (wr_en & (paddr_i == `TPG_OFS_CTRL) & pwdata_i[`TPG_CTRL_ARM]) | (armed_r & ~fire_sgl);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond timebase, restarted by every second pulse
  logic [15:0] cyc_r;
  logic [9:0]  ms_r;
  logic [3:0]  slot_r;
  logic [6:0]  bit_r;
  logic        ms_edge;
  logic [9:0]  ms_now;
  logic [3:0]  slot_now;
  logic [6:0]  bit_now;

  // all code timing counts from the disciplined second
  assign ms_edge  = pps_i | (cyc_r == 16'(`TPG_MS_CYC - 1));
  assign ms_now   = pps_i ? 10'h000 : ((ms_r == 10'h3E7) ? ms_r : ms_r + 10'h001);
  assign slot_now = pps_i ? 4'h0 : ((slot_r == 4'h9) ? 4'h0 : slot_r + 4'h1);
  assign bit_now  = pps_i ? 7'h00 : ((slot_r == 4'h9) ? bit_r + 7'h01 : bit_r);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_r  <= 16'h0000;
      ms_r   <= 10'h000;
      slot_r <= 4'h0;
      bit_r  <= 7'h64;
    end else begin
      cyc_r <= ms_edge ? 16'h0000 : cyc_r + 16'h0001;
      if (ms_edge) begin
        ms_r   <= ms_now;
        slot_r <= slot_now;
        bit_r  <= (bit_now > 7'h64) ? 7'h64 : bit_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode switch and seconds-per-pulse counter
  tpg_pkg::tpg_mode_t mode_now;
  logic [15:0] spp_cnt_r;

  // new mode and polarity only at a second boundary
  assign mode_now = pps_i ? mode_cfg_r : mode_act_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_act_r <= tpg_pkg::TPG_MODE_OFF;
      pol_act_r  <= 1'b0;
    end else if (pps_i) begin
      mode_act_r <= mode_cfg_r;
      pol_act_r  <= pol_neg_r;
    end
  end

  // count seconds, pulse on count zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      spp_cnt_r <= 16'h0000;
    else if (pps_i) begin
      // The pps that enters the mode fires, so it must count as second zero
      if (mode_now != tpg_pkg::TPG_MODE_SPP || spp_cnt_r + 16'h0001 >= period_r)
        spp_cnt_r <= 16'h0000;
      else
        spp_cnt_r <= spp_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-code frames
  logic [4:0]  loc_hour;
  logic [5:0]  hsum;
  logic [7:0]  bmin;
  logic [7:0]  bhour;
  logic [7:0]  bday;
  logic [7:0]  bmon;
  logic [7:0]  byear;
  logic [59:0] dcf;
  logic [99:0] irig_one;
  logic [99:0] irig_ref;
  logic [7:0]  isec;
  logic [7:0]  imin;
  logic [7:0]  ihr;
  logic [3:0]  dhun;
  logic [7:0]  dlow;

  // local zone is UTC+1 standard, UTC+2 summer
  assign hsum     = {1'b0, utc_hour_i} + (summer_time_i ? 6'd2 : 6'd1);
  assign loc_hour = (hsum >= 6'd24) ? 5'(hsum - 6'd24) : hsum[4:0];
  assign bmin     = bcd8({1'b0, utc_min_i});
  assign bhour    = bcd8({2'b00, loc_hour});
  assign bday     = bcd8({2'b00, mday_i});
  assign bmon     = bcd8({3'b000, month_i});
  assign byear    = bcd8(year_i);

  always_comb begin
    dcf        = 60'h0;
    dcf[15]    = svc_req_r;
    dcf[16]    = zone_change_pending_i;
    dcf[17]    = summer_time_i;
    dcf[18]    = ~summer_time_i;
    dcf[19]    = leap_pending_i;
    dcf[20]    = 1'b1;
    dcf[27:21] = bmin[6:0];
    dcf[34:29] = bhour[5:0];
    dcf[41:36] = bday[5:0];
    dcf[44:42] = wday_i;
    dcf[49:45] = bmon[4:0];
    dcf[57:50] = byear;
    dcf[28]    = ^dcf[27:21];
    dcf[35]    = ^dcf[34:29];
    dcf[58]    = ^dcf[57:36];
  end

  assign isec = bcd8({1'b0, utc_sec_i});
  assign imin = bcd8({1'b0, utc_min_i});
  assign ihr  = bcd8({2'b00, utc_hour_i});
  assign dhun = 4'(day_of_year_i / 9'd100);
  assign dlow = bcd8(7'(day_of_year_i - 9'(dhun * 9'd100)));

  // independent unmodulated IRIG-B frame, rebuilt each second
  always_comb begin
    irig_one        = 100'h0;
    irig_one[4:1]   = isec[3:0];
    irig_one[8:6]   = isec[6:4];
    irig_one[13:10] = imin[3:0];
    irig_one[17:15] = imin[6:4];
    irig_one[23:20] = ihr[3:0];
    irig_one[26:25] = ihr[5:4];
    irig_one[33:30] = dlow[3:0];
    irig_one[38:35] = dlow[7:4];
    irig_one[41:40] = dhun[1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 100; gi++) begin : g_ref
      assign irig_ref[gi] = (gi == 0) || ((gi % 10) == 9);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pulse start decision
  logic        start;
  logic [15:0] start_w;
  logic        time_hit;

  assign time_hit = (utc_hour_i == m_hour_r) && (utc_min_i == m_min_r)
                 && (utc_sec_i == m_sec_r) && ms_edge && (ms_now == m_ms_r);
  assign fire_sgl = (mode_now == tpg_pkg::TPG_MODE_SGL) && armed_r && time_hit
                 && (day_of_year_i == m_day_r);

  always_comb begin
    start   = 1'b0;
    start_w = width_r;
    case (mode_now)
      tpg_pkg::TPG_MODE_SPP:
        start = pps_i && (period_r != 16'h0000) && (spp_cnt_r == 16'h0000);
      tpg_pkg::TPG_MODE_PPH:
        start = pps_i && (12'(utc_min_i * 12'd60) + {6'h00, utc_sec_i} == hour_ofs_r);
      tpg_pkg::TPG_MODE_PPD:
        start = time_hit;
      tpg_pkg::TPG_MODE_SGL:
        start = fire_sgl;
      tpg_pkg::TPG_MODE_SLOW: begin
        start = pps_i && (utc_sec_i == 6'h00);
        if (utc_min_i != 6'h00)
          start_w = `TPG_SLOW_MIN_MS;
        else if (utc_hour_i != 5'h00)
          start_w = `TPG_SLOW_HOUR_MS;
        else
          start_w = `TPG_SLOW_DAY_MS;
      end
      tpg_pkg::TPG_MODE_IRIG: begin
        start = ms_edge && (slot_now == 4'h0) && (bit_now < 7'h64);
        if (irig_ref[bit_now])
          start_w = `TPG_IRIG_REF_MS;
        else if (irig_one[bit_now])
          start_w = `TPG_IRIG_ONE_MS;
        else
          start_w = `TPG_IRIG_ZERO_MS;
      end
      tpg_pkg::TPG_MODE_DCF: begin
        if (utc_sec_i >= 6'd59) begin
          start   = pps_i && dcf_mod_r;
          start_w = `TPG_DCF_MOD59_MS;
        end else begin
          // second 0 carries a zero, the minute marker
          start   = pps_i;
          start_w = dcf[utc_sec_i] ? `TPG_DCF_ONE_MS : `TPG_DCF_ZERO_MS;
        end
      end
      default: start = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse width counter and output
  logic [15:0] wl_r;
  logic [15:0] wl_nxt;
  logic        inv_nxt;

  always_comb begin
    wl_nxt = wl_r;
    // A mode change ends the running pulse so modes never overlap
    if (pps_i && (mode_cfg_r != mode_act_r))
      wl_nxt = 16'h0000;
    else if (ms_edge && (wl_r != 16'h0000))
      wl_nxt = wl_r - 16'h0001;
    if (start)
      wl_nxt = start_w;
  end

  // inversion for programmable pulse modes and slow code; none for IRIG, time-code or off
  assign inv_nxt = (pps_i ? pol_neg_r : pol_act_r) && (mode_now != tpg_pkg::TPG_MODE_IRIG)
                && (mode_now != tpg_pkg::TPG_MODE_DCF) && (mode_now != tpg_pkg::TPG_MODE_OFF);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wl_r  <= 16'h0000;
      out_r <= 1'b0;
    end else begin
      wl_r  <= wl_nxt;
      out_r <= (wl_nxt != 16'h0000) ^ inv_nxt;
    end
  end

  assign pulse_o = out_r;

endmodule

/* File: tb/tb_tpg_pulse_gen.sv */
/*
 * Self-checking bench for the programmable pulse generator.
 * Drives APB and a timebase model; second starts come far faster than real.
 */
`timescale 1ns/1ns
`include "tpg_cfg.svh"
module tb_tpg_pulse_gen;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        pps_i;
  logic [5:0]  utc_sec_i;
  logic [5:0]  utc_min_i;
  logic [4:0]  utc_hour_i;
  logic [8:0]  doy_r = 9'h064;
  logic        summer_r = 1'b0;
  logic        pulse_o;
  logic        ld_r = 1'b0;
  logic        adv_r = 1'b0;
  logic [5:0]  ld_sec_r = 6'h00;
  logic [5:0]  ld_min_r = 6'h00;
  logic [4:0]  ld_hour_r = 5'h00;
  logic [31:0] q;
  logic        e;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc_cnt = 0;
  int          n;
  ////////////////////////////////////////////////////////////////////////////
  tpg_pulse_gen u_tpg_pulse_gen (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pps_i(pps_i), .utc_sec_i(utc_sec_i),
    .utc_min_i(utc_min_i), .utc_hour_i(utc_hour_i), .day_of_year_i(doy_r), .year_i(7'h19),
    .month_i(4'h6), .mday_i(5'h0F), .wday_i(3'h3), .summer_time_i(summer_r),
    .zone_change_pending_i(summer_r), .leap_pending_i(summer_r), .pulse_o(pulse_o));
  tpg_timebase_model u_tpg_timebase_model (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .load_i(ld_r), .adv_i(adv_r), .sec_i(ld_sec_r),
    .min_i(ld_min_r), .hour_i(ld_hour_r), .pps_o(pps_i), .sec_o(utc_sec_i),
    .min_o(utc_min_i), .hour_o(utc_hour_i));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 80000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ready is sampled high, then releases it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    // Only the bench timeout ends a wait for ready
    while (pready_o !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic        de;
    xfer(1'b1, a, d, dq, de);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] rq);
    logic de;
    xfer(1'b0, a, 32'h0000_0000, rq, de);
  endtask
  // One second start; returns in the first cycle of the new second's output
  task automatic tick(input logic a, input logic [5:0] s, input logic [5:0] m, input logic [4:0] h);
    @(posedge clk_sys_i);
    ld_r <= !a;
    adv_r <= a;
    ld_sec_r <= s;
    ld_min_r <= m;
    ld_hour_r <= h;
    @(posedge clk_sys_i);
    ld_r <= 1'b0;
    adv_r <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  // Enter a mode from off at one second start, then switch off again
  task automatic fire(input logic [31:0] c, input logic [5:0] s, input logic [5:0] m,
                      input logic [4:0] h, input logic x);
    wr(`TPG_OFS_CTRL, c);
    tick(1'b0, s, m, h);
    check(32'(pulse_o), 32'(x));
    wr(`TPG_OFS_CTRL, 32'h0000_0000);
    tick(1'b0, s, m, h);
    check(32'(pulse_o), 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys_i);
    check(32'(pulse_o), 32'h0000_0000);
    rstn_i <= 1'b1;
    rd(`TPG_OFS_WIDTH, q);
    check(q, 32'h0000_000A);
    rd(`TPG_OFS_STATUS, q);
    check(q, 32'h0000_0000);
    xfer(1'b0, 12'h01C, 32'h0000_0000, q, e);
    check({q[30:0], e}, 32'h0000_0001);
    wr(`TPG_OFS_PERIOD, 32'h0000_FFFF);
    rd(`TPG_OFS_PERIOD, q);
    check(q, 32'h0000_EA60);
    wr(`TPG_OFS_HOUR_OFS, 32'h0000_0FFF);
    rd(`TPG_OFS_HOUR_OFS, q);
    check(q, 32'h0000_0E0F);
    // Seconds per pulse, N = 2, one ms wide
    wr(`TPG_OFS_PERIOD, 32'h0000_0002);
    wr(`TPG_OFS_WIDTH, 32'h0000_0001);
    wr(`TPG_OFS_CTRL, 32'h0000_0001);
    tick(1'b0, 6'h00, 6'h00, 5'h00);
    check(32'(pulse_o), 32'h0000_0001);
    n = 0;
    while (pulse_o === 1'b1 && n < 60000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(32'(n), 32'(`TPG_MS_CYC));
    tick(1'b1, 6'h00, 6'h00, 5'h00);
    check(32'(pulse_o), 32'h0000_0000);
    tick(1'b1, 6'h00, 6'h00, 5'h00);
    check(32'(pulse_o), 32'h0000_0001);
    wr(`TPG_OFS_CTRL, 32'h0000_0000);
    wr(`TPG_OFS_WIDTH, 32'h0000_0000);
    tick(1'b0, 6'h00, 6'h00, 5'h00);
    fire(32'h0000_0001, 6'h00, 6'h00, 5'h00, 1'b0);
    wr(`TPG_OFS_WIDTH, 32'h0000_0001);
    // Hourly at 65 s, with and without inverted polarity
    wr(`TPG_OFS_HOUR_OFS, 32'h0000_0041);
    fire(32'h0000_0002, 6'h05, 6'h01, 5'h00, 1'b1);
    fire(32'h0000_0002, 6'h04, 6'h01, 5'h00, 1'b0);
    fire(32'h0000_000A, 6'h04, 6'h01, 5'h00, 1'b1);
    fire(32'h0000_000A, 6'h05, 6'h01, 5'h00, 1'b0);
    // Daily and single trigger at 03:04:05.000, day 100
    wr(`TPG_OFS_MATCH, 32'h00C4_1400);
    fire(32'h0000_0003, 6'h05, 6'h04, 5'h03, 1'b1);
    fire(32'h0000_0003, 6'h05, 6'h04, 5'h02, 1'b0);
    wr(`TPG_OFS_DAY, 32'h0000_0064);
    @(posedge clk_sys_i);
    doy_r <= 9'h063;
    fire(32'h0000_0104, 6'h05, 6'h04, 5'h03, 1'b0);
    @(posedge clk_sys_i);
    doy_r <= 9'h064;
    fire(32'h0000_0104, 6'h05, 6'h04, 5'h03, 1'b1);
    rd(`TPG_OFS_STATUS, q);
    check(q, 32'h0000_0000);
    fire(32'h0000_0004, 6'h05, 6'h04, 5'h03, 1'b0);
    // Slow code; the mode waits for the next second start
    wr(`TPG_OFS_CTRL, 32'h0000_0005);
    rd(`TPG_OFS_STATUS, q);
    check(q, 32'h0000_0000);
    tick(1'b0, 6'h00, 6'h07, 5'h05);
    rd(`TPG_OFS_STATUS, q);
    check(q, 32'h0000_0015);
    fire(32'h0000_0005, 6'h00, 6'h00, 5'h00, 1'b1);
    fire(32'h0000_0005, 6'h1E, 6'h07, 5'h05, 1'b0);
    fire(32'h0000_000D, 6'h00, 6'h07, 5'h05, 1'b0);
    // Own IRIG-B instance ignores polarity
    fire(32'h0000_0006, 6'h00, 6'h07, 5'h05, 1'b1);
    fire(32'h0000_000E, 6'h00, 6'h07, 5'h05, 1'b1);
    // Minute frame seconds
    @(posedge clk_sys_i);
    summer_r <= 1'b1;
    fire(32'h0000_0007, 6'h3B, 6'h07, 5'h05, 1'b0);
    fire(32'h0000_0017, 6'h3B, 6'h07, 5'h05, 1'b1);
    fire(32'h0000_0007, 6'h00, 6'h07, 5'h05, 1'b1);
    fire(32'h0000_0027, 6'h0F, 6'h07, 5'h05, 1'b1);
    fire(32'h0000_0007, 6'h01, 6'h07, 5'h05, 1'b1);
    finish_test();
  end
endmodule

/* File: tb/tpg_pulse_gen_asserts.sv */
/*
 * Port-level assertions for the programmable pulse generator.
 * Bound into tpg_pulse_gen; sees only its ports and snoops CTRL writes.
 */
`timescale 1ns/1ns
`include "tpg_cfg.svh"
module tpg_pulse_gen_asserts (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        pps_i,
  input  wire logic [5:0]  utc_sec_i,
  input  wire logic        pulse_o
);
  logic [5:0]  ctrl_r;
  logic [2:0]  act_r;
  logic [31:0] since_r;
  wire         wr_ctrl = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == `TPG_OFS_CTRL);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= 6'h00;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata_i[5:0];
    end
  end
  // Mode in force: taken over at each second start, like the design
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_r <= 3'h0;
    end else if (pps_i) begin
      act_r <= ctrl_r[2:0];
    end
  end
  // Cycles since the last second start; 1 in the first cycle after it
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_r <= 32'h0000_0000;
    end else if (pps_i) begin
      since_r <= 32'h0000_0001;
    end else if (since_r != 32'hFFFF_FFFF) begin
      since_r <= since_r + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_rdy_wait;
    psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o ##1 !pready_o;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not one wait state");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdata;
    (!pready_o || pwrite_i) |-> prdata_o == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read answer");
  property p_edge;
    $changed(pulse_o) |-> (since_r % `TPG_MS_CYC) == 1;
  endproperty
  a_edge: assert property (p_edge) else $error("output moved off a ms boundary");
  property p_off;
    act_r == 3'h0 |-> !pulse_o;
  endproperty
  a_off: assert property (p_off) else $error("output active with mode off");
  property p_slow;
    pps_i && ctrl_r[2:0] == 3'h5 && utc_sec_i == 6'h00 |=> pulse_o == !ctrl_r[3];
  endproperty
  a_slow: assert property (p_slow) else $error("slow code minute pulse missing");
  property p_dcf59;
    pps_i && ctrl_r[2:0] == 3'h7 && act_r != 3'h7 && utc_sec_i == 6'h3B |=> pulse_o == ctrl_r[4];
  endproperty
  a_dcf59: assert property (p_dcf59) else $error("second 59 wrong");
  property p_dcf_start;
    pps_i && ctrl_r[2:0] == 3'h7 && act_r != 3'h7 && utc_sec_i < 6'h3B |=> pulse_o;
  endproperty
  a_dcf_start: assert property (p_dcf_start) else $error("second start pulse missing");
  property p_irig;
    pps_i && ctrl_r[2:0] == 3'h6 && act_r != 3'h6 |=> pulse_o ##1 pulse_o;
  endproperty
  a_irig: assert property (p_irig) else $error("reference slot missing");
  c_ctrl: cover property (wr_ctrl);
  c_slow: cover property (pps_i && ctrl_r[2:0] == 3'h5);
  c_fall: cover property ($fell(pulse_o));
endmodule

bind tpg_pulse_gen tpg_pulse_gen_asserts u_tpg_pulse_gen_asserts (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pps_i(pps_i), .utc_sec_i(utc_sec_i),
  .pulse_o(pulse_o));

/* File: tb/tpg_timebase_model.sv */
/*
 * Disciplined timebase standing in front of the generator.
 * Bench loads a time (announced with a second start) or advances one second.
 */
`timescale 1ns/1ns
module tpg_timebase_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       load_i,
  input  wire logic       adv_i,
  input  wire logic [5:0] sec_i,
  input  wire logic [5:0] min_i,
  input  wire logic [4:0] hour_i,
  output logic            pps_o,
  output logic      [5:0] sec_o,
  output logic      [5:0] min_o,
  output logic      [4:0] hour_o
);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pps_o <= 1'b0;
    end else begin
      pps_o <= load_i | adv_i;
    end
  end
  // Time fields change only with the second start, so they stand all second
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_o  <= 6'h00;
      min_o  <= 6'h00;
      hour_o <= 5'h00;
    end else if (load_i) begin
      sec_o  <= sec_i;
      min_o  <= min_i;
      hour_o <= hour_i;
    end else if (adv_i) begin
      sec_o <= (sec_o == 6'h3B) ? 6'h00 : sec_o + 6'h01;
      if (sec_o == 6'h3B) begin
        min_o <= (min_o == 6'h3B) ? 6'h00 : min_o + 6'h01;
        if (min_o == 6'h3B) begin
          hour_o <= (hour_o == 5'h17) ? 5'h00 : hour_o + 5'h01;
        end
      end
    end
  end
endmodule
